/* pkg/aec_pkg.sv */
// Package of constants and types for the access exception checks block.
package aec_pkg;

    // ------------------------------------------------------------
    // Register bus offsets
    // ------------------------------------------------------------
    localparam logic [7:0] AEC_SCR_BASE = 8'h00;
    localparam logic [7:0] AEC_GL_OFF = 8'h08;
    localparam logic [7:0] AEC_FPRS_OFF = 8'h09;
    localparam logic [7:0] AEC_STAT_OFF = 8'h0A;
    localparam logic [7:0] AEC_CLR_OFF = 8'h0B;
    localparam logic [7:0] AEC_EN_OFF = 8'h0C;
    localparam logic [7:0] AEC_CFG_OFF = 8'h0D;

    // ------------------------------------------------------------
    // Design constants
    // ------------------------------------------------------------
    localparam logic [3:0] AEC_MAX_GL = 4'h3;
    localparam logic [3:0] AEC_GL_MASK = 4'h3;
    localparam int AEC_VA_BITS = 48;
    localparam logic [2:0] AEC_SLOW_LAT = 3'h4;
    localparam logic [2:0] AEC_SCR_HI_IDX = 3'h4;
    localparam logic [7:0] AEC_PS_ASI_A = 8'hC0;
    localparam logic [7:0] AEC_PS_ASI_B = 8'hC5;
    localparam logic [7:0] AEC_PS_ASI_C = 8'hC8;
    localparam logic [7:0] AEC_PS_ASI_D = 8'hCD;
    localparam logic [5:0] AEC_FREG_HALF = 6'h20;
    localparam logic [7:0] AEC_CFG_RST = 8'h05;

    // Status bit positions.
    localparam int AEC_ST_PRIV = 0;
    localparam int AEC_ST_DAE = 1;
    localparam int AEC_ST_ILL = 2;
    localparam int AEC_ST_ALIGN = 3;
    localparam int AEC_ST_WATCH = 4;
    localparam int AEC_ST_W = 5;

    // Config bit positions.
    localparam int AEC_CF_COHERENT = 0;
    localparam int AEC_CF_STRICT = 1;
    localparam int AEC_CF_BYTEMASK = 2;
    localparam int AEC_CF_MASKPC = 3;

    typedef enum logic [3:0] {
        AEC_OP_NONE,
        AEC_OP_RD_PCR,
        AEC_OP_WR_PCR,
        AEC_OP_PAIR_LD,
        AEC_OP_PAIR_ST,
        AEC_OP_QUAD_LD,
        AEC_OP_DF_LD,
        AEC_OP_FLUSH,
        AEC_OP_BLK_LD,
        AEC_OP_BLK_ST,
        AEC_OP_PART_ST,
        AEC_OP_LOAD,
        AEC_OP_STORE
    } aec_op_type;

    typedef enum logic [2:0] {
        AEC_EXC_NONE,
        AEC_EXC_PRIV_OPCODE,
        AEC_EXC_DATA_ACCESS,
        AEC_EXC_ILLEGAL,
        AEC_EXC_MISALIGN,
        AEC_EXC_WATCH
    } aec_exc_type;

    typedef enum logic [1:0] {
        AEC_SCR_FULL,
        AEC_SCR_SLOW,
        AEC_SCR_NONE
    } aec_scr_mode_type;

    typedef struct packed {
        aec_op_type op;
        logic [63:0] va;
        logic [7:0] asi;
        logic priv;
        logic mem_space;
        logic cacheable;
        logic [7:0] byte_mask;
    } aec_req_type;

    typedef struct packed {
        aec_exc_type exc;
        logic do_access;
        logic mmu_lookup;
        logic va_valid;
    } aec_rsp_type;

endpackage

/* hw/aec_core.sv */
// Access exception checks of the load/store and privileged-state path.
`timescale 1ns/1ns
//
// Notes on behaviour
// - Unprivileged perf-control access raises privileged fault.
// - Paired alt load to non-memory faults.
// - Paired alt store to non-memory faults.
// - Atomic quad load non-cacheable raises fault.
// - Misaligned partial-store double load raises exception.
// - Eight 64-bit privileged scratch registers, read/write.
// - Scratch 4-7 full, slow, or faulting.
// - Unimplemented level bits read zero, ignore writes.
// - Maximum global level fixed between 2 and 15.
// - FP dirty bit set on register modify.
// - Valid addresses only bottom and top halves.
// - Coherent sync ignores address, never faults.
// - Non-coherent sync translates, may fault.
// - Non-cacheable block loads ordered or illegal.
// - Unordered non-cacheable block store is illegal.
// - Watch covers all 64 block bytes.
// - Watch covers all 16 quad bytes.
// - Partial store watch uses mask or all.
// - Trap return restores mask, optionally zeroes upper 32 bits of PC and NPC.
module aec_core
    import aec_pkg::*;
#(
    parameter aec_scr_mode_type SCR4_MODE = AEC_SCR_FULL,
    parameter aec_scr_mode_type SCR5_MODE = AEC_SCR_FULL,
    parameter aec_scr_mode_type SCR6_MODE = AEC_SCR_SLOW,
    parameter aec_scr_mode_type SCR7_MODE = AEC_SCR_NONE
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire aec_req_type req_i,
    input wire logic [63:0] watch_va_i,
    input wire logic [7:0] watch_mask_i,
    input wire logic watch_en_i,
    input wire logic fp_wr_i,
    input wire logic [5:0] fp_wr_reg_i,
    input wire logic trap_ret_i,
    input wire logic saved_am_i,
    input wire logic [63:0] ret_pc_i,
    input wire logic [63:0] ret_npc_i,
    input wire logic [7:0] addr_i,
    input wire logic [63:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic reg_priv_i,
    output logic [63:0] rdata_o,
    output logic reg_fault_o,
    output logic reg_busy_o,
    output aec_rsp_type rsp_o,
    output logic rsp_valid_o,
    output logic address_mask_bit_o,
    output logic [63:0] pc_o,
    output logic [63:0] npc_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic is_ps_asi(input logic [7:0] asi);
        is_ps_asi = (asi >= AEC_PS_ASI_A && asi <= AEC_PS_ASI_B) ||
                    (asi >= AEC_PS_ASI_C && asi <= AEC_PS_ASI_D);
    endfunction

    // Access of len bytes from va overlaps the watched doubleword.
    function automatic logic watch_hit(input logic [63:0] va,
                                       input logic [6:0] len,
                                       input logic [63:0] wva,
                                       input logic [7:0] wmask,
                                       input logic [7:0] bmask);
        logic hit;
        logic [63:0] a;
        hit = 1'b0;
        a = 64'h0;
        for (int i = 0; i < 64; i++)
        begin
            a = va + 64'(i);
            if (7'(i) < len && a[63:3] == wva[63:3] &&
                wmask[a[2:0]] && bmask[a[2:0]])
            begin
                hit = 1'b1;
            end
        end
        watch_hit = hit;
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [63:0] scr_mem [8];
    logic [3:0] gl_reg;
    logic [1:0] dirty_reg;
    logic [AEC_ST_W-1:0] stat_reg;
    logic [AEC_ST_W-1:0] en_reg;
    logic [7:0] cfg_reg;
    logic [2:0] slow_cnt_reg;
    logic [63:0] rdata_reg;
    logic fault_reg;
    logic am_reg;
    logic [63:0] pc_reg;
    logic [63:0] npc_reg;
    aec_rsp_type rsp_reg;
    logic rsp_valid_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic sel_scr = addr_i[7:3] == AEC_SCR_BASE[7:3];
    wire logic [2:0] scr_idx = addr_i[2:0];
    wire aec_scr_mode_type scr_mode =
        scr_idx < AEC_SCR_HI_IDX ? AEC_SCR_FULL :
        scr_idx == AEC_SCR_HI_IDX ? SCR4_MODE :
        scr_idx == 3'h5 ? SCR5_MODE :
        scr_idx == 3'h6 ? SCR6_MODE : SCR7_MODE;
    wire logic scr_acc = sel_scr && (wr_i || rd_i);
    wire logic scr_ok = scr_acc && reg_priv_i && scr_mode != AEC_SCR_NONE;
    wire logic scr_fault = scr_acc &&
        (!reg_priv_i || scr_mode == AEC_SCR_NONE);
    // slow entries flag busy
    // The bus never waits, so a slow entry answers in time and then
    // shows busy for the settling span that software must let pass.
    wire logic scr_slow = scr_ok && scr_mode == AEC_SCR_SLOW;
    wire logic scr_do = scr_ok;
    wire logic scr_wr = scr_do && wr_i;
    wire logic gl_wr = wr_i && addr_i == AEC_GL_OFF;
    wire logic clr_wr = wr_i && addr_i == AEC_CLR_OFF;
    wire logic en_wr = wr_i && addr_i == AEC_EN_OFF;
    wire logic cfg_wr = wr_i && addr_i == AEC_CFG_OFF;
    wire logic fprs_wr = wr_i && addr_i == AEC_FPRS_OFF;

    wire logic [3:0] gl_next = (wdata_i[3:0] & AEC_GL_MASK) > AEC_MAX_GL ?
        AEC_MAX_GL : wdata_i[3:0] & AEC_GL_MASK;

    wire logic [63:0] rd_mux =
        sel_scr ? (scr_do ? scr_mem[scr_idx] : 64'h0) :
        addr_i == AEC_GL_OFF ? {60'h0, gl_reg} :
        addr_i == AEC_FPRS_OFF ? {62'h0, dirty_reg} :
        addr_i == AEC_STAT_OFF ? {59'h0, stat_reg} :
        addr_i == AEC_EN_OFF ? {59'h0, en_reg} :
        addr_i == AEC_CFG_OFF ? {56'h0, cfg_reg} : 64'h0;

    // ------------------------------------------------------------
    // Access checks
    // ------------------------------------------------------------
    // two valid halves
    wire logic [64-AEC_VA_BITS:0] va_top = req_i.va[63:AEC_VA_BITS-1];
    wire logic va_ok = (va_top == '0) || (va_top == '1);
    wire logic coherent = cfg_reg[AEC_CF_COHERENT];
    wire logic strict = cfg_reg[AEC_CF_STRICT];
    wire logic [7:0] bmask = cfg_reg[AEC_CF_BYTEMASK] ?
        req_i.byte_mask : 8'hFF;
    wire logic [6:0] acc_len =
        (req_i.op == AEC_OP_BLK_LD || req_i.op == AEC_OP_BLK_ST) ? 7'h40 :
        req_i.op == AEC_OP_QUAD_LD ? 7'h10 : 7'h08;
    wire logic wp = watch_en_i && req_i.op != AEC_OP_FLUSH &&
        req_i.op != AEC_OP_RD_PCR && req_i.op != AEC_OP_WR_PCR &&
        watch_hit(req_i.va, acc_len, watch_va_i, watch_mask_i,
                  req_i.op == AEC_OP_PART_ST ? bmask : 8'hFF);

    aec_exc_type exc;
    always_comb
    begin
        exc = AEC_EXC_NONE;
        unique case (req_i.op)
            AEC_OP_RD_PCR, AEC_OP_WR_PCR:
                if (!req_i.priv) exc = AEC_EXC_PRIV_OPCODE;
            AEC_OP_PAIR_LD, AEC_OP_PAIR_ST:
                if (!req_i.mem_space) exc = AEC_EXC_DATA_ACCESS;
            AEC_OP_QUAD_LD:
                if (!req_i.cacheable) exc = AEC_EXC_DATA_ACCESS;
            AEC_OP_DF_LD:
                if (is_ps_asi(req_i.asi) && req_i.va[2:0] != 3'h0)
                    exc = AEC_EXC_MISALIGN;
            AEC_OP_FLUSH:
                if (!coherent && !va_ok) exc = AEC_EXC_DATA_ACCESS;
            AEC_OP_BLK_LD, AEC_OP_BLK_ST:
                if (!req_i.cacheable && !strict) exc = AEC_EXC_ILLEGAL;
            default:
                exc = AEC_EXC_NONE;
        endcase
        if (exc == AEC_EXC_NONE && req_i.op != AEC_OP_FLUSH &&
            req_i.op != AEC_OP_RD_PCR && req_i.op != AEC_OP_WR_PCR)
        begin
            if (!va_ok) exc = AEC_EXC_DATA_ACCESS;
            else if (wp) exc = AEC_EXC_WATCH;
        end
    end

    aec_rsp_type rsp_next;
    always_comb
    begin
        rsp_next.exc = exc;
        rsp_next.do_access = req_i.op != AEC_OP_NONE && exc == AEC_EXC_NONE &&
            req_i.op != AEC_OP_FLUSH;
        rsp_next.mmu_lookup = req_i.op != AEC_OP_RD_PCR &&
            req_i.op != AEC_OP_WR_PCR &&
            !(req_i.op == AEC_OP_FLUSH && coherent);
        rsp_next.va_valid = va_ok;
    end

    wire logic [AEC_ST_W-1:0] ev = !req_valid_i ? '0 : {
        exc == AEC_EXC_WATCH, exc == AEC_EXC_MISALIGN,
        exc == AEC_EXC_ILLEGAL, exc == AEC_EXC_DATA_ACCESS,
        exc == AEC_EXC_PRIV_OPCODE};
    wire logic [AEC_ST_W-1:0] ev_all = ev |
        {3'h0, scr_fault, 1'b0};

    wire logic [1:0] dirty_set = !fp_wr_i ? 2'h0 :
        fp_wr_reg_i >= AEC_FREG_HALF ? 2'h2 : 2'h1;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (scr_wr)
            scr_mem[scr_idx] <= wdata_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            gl_reg <= 4'h0;
            dirty_reg <= 2'h0;
            stat_reg <= '0;
            en_reg <= '0;
            cfg_reg <= AEC_CFG_RST;
            slow_cnt_reg <= 3'h0;
            rdata_reg <= 64'h0;
            fault_reg <= 1'b0;
        end
        else
        begin
            if (gl_wr) gl_reg <= gl_next;
            dirty_reg <= (fprs_wr ? wdata_i[1:0] : dirty_reg) | dirty_set;
            stat_reg <= (stat_reg & ~(clr_wr ? wdata_i[AEC_ST_W-1:0] : '0))
                | ev_all;
            if (en_wr) en_reg <= wdata_i[AEC_ST_W-1:0];
            if (cfg_wr) cfg_reg <= wdata_i[7:0];
            slow_cnt_reg <= scr_slow ? AEC_SLOW_LAT :
                slow_cnt_reg != 3'h0 ? slow_cnt_reg - 3'h1 : 3'h0;
            rdata_reg <= rd_i ? rd_mux : 64'h0;
            fault_reg <= scr_fault;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rsp_reg <= '0;
            rsp_valid_reg <= 1'b0;
            am_reg <= 1'b0;
            pc_reg <= 64'h0;
            npc_reg <= 64'h0;
        end
        else
        begin
            rsp_valid_reg <= req_valid_i;
            if (req_valid_i) rsp_reg <= rsp_next;
            if (trap_ret_i)
            begin
                am_reg <= saved_am_i;
                pc_reg <= saved_am_i && cfg_reg[AEC_CF_MASKPC] ?
                    {32'h0, ret_pc_i[31:0]} : ret_pc_i;
                npc_reg <= saved_am_i && cfg_reg[AEC_CF_MASKPC] ?
                    {32'h0, ret_npc_i[31:0]} : ret_npc_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_o = rdata_reg;
    assign reg_fault_o = fault_reg;
    assign reg_busy_o = slow_cnt_reg != 3'h0;
    assign rsp_o = rsp_reg;
    assign rsp_valid_o = rsp_valid_reg;
    assign address_mask_bit_o = am_reg;
    assign pc_o = pc_reg;
    assign npc_o = npc_reg;
    assign irq_o = |(stat_reg & en_reg);

endmodule // aec_core

/* sim/aec_core_checker.sv */
// Port checker for the access exception checks block.
`timescale 1ns/1ns
module aec_core_checker
    import aec_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_valid_i,
    input wire aec_req_type req_i,
    input wire logic trap_ret_i,
    input wire logic saved_am_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [63:0] rdata_o,
    input wire logic reg_fault_o,
    input wire aec_rsp_type rsp_o,
    input wire logic rsp_valid_o,
    input wire logic address_mask_bit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic rq = req_valid_i && req_i.priv;
    wire logic ps = (req_i.asi >= AEC_PS_ASI_A && req_i.asi <= AEC_PS_ASI_B)
        || (req_i.asi >= AEC_PS_ASI_C && req_i.asi <= AEC_PS_ASI_D);
    wire logic dae = rsp_valid_o && rsp_o.exc == AEC_EXC_DATA_ACCESS;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pcr_priv_fault: assert property (
        req_valid_i && !req_i.priv && (req_i.op == AEC_OP_RD_PCR
        || req_i.op == AEC_OP_WR_PCR) |=> rsp_valid_o && !rsp_o.do_access
        && rsp_o.exc == AEC_EXC_PRIV_OPCODE) else $error("pcr not refused");
    a_pair_load: assert property (
        rq && req_i.op == AEC_OP_PAIR_LD && !req_i.mem_space
        |=> dae && !rsp_o.do_access) else $error("pair load not refused");
    a_pair_store: assert property (
        rq && req_i.op == AEC_OP_PAIR_ST && !req_i.mem_space
        |=> dae && !rsp_o.do_access) else $error("pair store not refused");
    a_quad_uncached: assert property (
        rq && req_i.op == AEC_OP_QUAD_LD && !req_i.cacheable
        |=> dae) else $error("quad load not refused");
    a_df_misalign: assert property (
        rq && req_i.op == AEC_OP_DF_LD && ps && req_i.va[2:0] != 3'h0
        |=> rsp_o.exc == AEC_EXC_MISALIGN) else $error("no misalign");
    a_level_width: assert property (
        rd_i && addr_i == AEC_GL_OFF |=> rdata_o[63:2] == 62'h0
        && rdata_o[3:0] <= AEC_MAX_GL) else $error("level width bad");
    a_scratch_none: assert property (
        (rd_i || wr_i) && addr_i == 8'h07 |=> reg_fault_o
        && rdata_o == 64'h0) else $error("scratch 7 reachable");
    a_trap_mask: assert property (
        trap_ret_i |=> address_mask_bit_o == $past(saved_am_i))
        else $error("mask bit not restored");
    a_rsp_cause: assert property (
        rsp_valid_o |-> $past(req_valid_i)) else $error("stray response");
    c_pcr: cover property (rsp_valid_o && rsp_o.exc == AEC_EXC_PRIV_OPCODE);
    c_watch: cover property (rsp_valid_o && rsp_o.exc == AEC_EXC_WATCH);
    c_fault: cover property (reg_fault_o);
endmodule // aec_core_checker
bind aec_core aec_core_checker aec_core_checker_i (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .trap_ret_i(trap_ret_i), .saved_am_i(saved_am_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reg_fault_o(reg_fault_o),
    .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
    .address_mask_bit_o(address_mask_bit_o));

/* sim/aec_core_tb_top.sv */
// Self-checking testbench for the access exception checks block.
`timescale 1ns/1ns
module aec_core_tb_top
    import aec_pkg::*;
;
    typedef struct packed {
        aec_req_type r;
        aec_exc_type e;
    } aec_tb_row_type;
    logic clk_i, rst_b_i, req_valid_i, watch_en_i, fp_wr_i, trap_ret_i;
    logic saved_am_i, wr_i, rd_i, reg_priv_i, reg_fault_o, reg_busy_o;
    logic rsp_valid_o, address_mask_bit_o, irq_o, flt;
    logic [63:0] watch_va_i, ret_pc_i, ret_npc_i, wdata_i, rdata_o, rdv;
    logic [63:0] pc_o, npc_o;
    logic [7:0] watch_mask_i, addr_i;
    logic [5:0] fp_wr_reg_i;
    aec_req_type req_i;
    aec_rsp_type rsp_o, rsp;
    aec_tb_row_type rows [16];
    int n_mismatch = 0;
    int checks_done = 0;
    aec_core aec_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .watch_va_i(watch_va_i),
        .watch_mask_i(watch_mask_i), .watch_en_i(watch_en_i),
        .fp_wr_i(fp_wr_i), .fp_wr_reg_i(fp_wr_reg_i), .trap_ret_i(trap_ret_i),
        .saved_am_i(saved_am_i), .ret_pc_i(ret_pc_i), .ret_npc_i(ret_npc_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .reg_priv_i(reg_priv_i), .rdata_o(rdata_o), .reg_fault_o(reg_fault_o),
        .reg_busy_o(reg_busy_o), .rsp_o(rsp_o), .rsp_valid_o(rsp_valid_o),
        .address_mask_bit_o(address_mask_bit_o), .pc_o(pc_o), .npc_o(npc_o),
        .irq_o(irq_o));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [63:0] s, e);
        checks_done++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One strobe cycle; read data stand in the cycle after it.
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [63:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= w;
        rd_i <= !w;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        #1;
        rdv = rdata_o;
        flt = reg_fault_o;
    endtask
    task automatic go(input aec_tb_row_type t);
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= t.r;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        rsp = rsp_o;
        chk("rsp_valid", rsp_valid_o, 64'h1);
    endtask
    task automatic trap(input logic am);
        @(posedge clk_i);
        trap_ret_i <= 1'b1;
        saved_am_i <= am;
        @(posedge clk_i);
        trap_ret_i <= 1'b0;
        #1;
    endtask
    function automatic aec_tb_row_type row(aec_op_type op, logic [63:0] va,
        logic [7:0] asi, logic [2:0] pmc, aec_exc_type e);
        row = '{'{op, va, asi, pmc[2], pmc[1], pmc[0], 8'h01}, e};
    endfunction
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_b_i, req_valid_i, fp_wr_i, trap_ret_i, saved_am_i} = 5'h0;
        {wr_i, rd_i, fp_wr_reg_i, addr_i, wdata_i} = 80'h0;
        req_i = '0;
        {reg_priv_i, watch_en_i, watch_mask_i} = 10'h3FF;
        watch_va_i = 64'h1000;
        ret_pc_i = 64'h1234_5678_9ABC_DEF0;
        ret_npc_i = 64'h1234_5678_9ABC_DEF4;
        rows[0] = row(AEC_OP_RD_PCR, 64'h0, 8'h00, 3'h3, AEC_EXC_PRIV_OPCODE);
        rows[1] = row(AEC_OP_WR_PCR, 64'h0, 8'h00, 3'h3, AEC_EXC_PRIV_OPCODE);
        rows[2] = row(AEC_OP_RD_PCR, 64'h0, 8'h00, 3'h7, AEC_EXC_NONE);
        rows[3] = row(AEC_OP_PAIR_LD, 64'h0, 8'h00, 3'h5, AEC_EXC_DATA_ACCESS);
        rows[4] = row(AEC_OP_PAIR_ST, 64'h0, 8'h00, 3'h5, AEC_EXC_DATA_ACCESS);
        rows[5] = row(AEC_OP_QUAD_LD, 64'h0, 8'h00, 3'h6, AEC_EXC_DATA_ACCESS);
        rows[6] = row(AEC_OP_DF_LD, 64'h4, AEC_PS_ASI_A, 3'h7, AEC_EXC_MISALIGN);
        rows[7] = row(AEC_OP_DF_LD, 64'h1, AEC_PS_ASI_B, 3'h7, AEC_EXC_MISALIGN);
        rows[8] = row(AEC_OP_DF_LD, 64'h2, AEC_PS_ASI_C, 3'h7, AEC_EXC_MISALIGN);
        rows[9] = row(AEC_OP_DF_LD, 64'h6, AEC_PS_ASI_D, 3'h7, AEC_EXC_MISALIGN);
        rows[10] = row(AEC_OP_LOAD, 64'h8000_0000_0000, 8'h00, 3'h7,
            AEC_EXC_DATA_ACCESS);
        rows[11] = row(AEC_OP_LOAD, 64'hFFFF_8000_0000_0000, 8'h00, 3'h7,
            AEC_EXC_NONE);
        rows[12] = row(AEC_OP_BLK_LD, 64'h0, 8'h00, 3'h6, AEC_EXC_ILLEGAL);
        rows[13] = row(AEC_OP_BLK_ST, 64'h0, 8'h00, 3'h6, AEC_EXC_ILLEGAL);
        rows[14] = row(AEC_OP_QUAD_LD, 64'hFF8, 8'h00, 3'h7, AEC_EXC_WATCH);
        rows[15] = row(AEC_OP_BLK_LD, 64'hFC8, 8'h00, 3'h7, AEC_EXC_WATCH);
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        acc(1'b0, AEC_CFG_OFF, 64'h0);
        chk("cfg_reset", rdv, {56'h0, AEC_CFG_RST});
        acc(1'b0, AEC_GL_OFF, 64'h0);
        chk("level_reset", rdv, 64'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++)
        begin
            go(rows[i]);
            chk("exc", rsp.exc, rows[i].e);
            chk("do", rsp.do_access, rows[i].e == AEC_EXC_NONE);
            chk("va_valid", rsp.va_valid, i != 10);
        end
        go(row(AEC_OP_PART_ST, 64'h1000, 8'h00, 3'h7, AEC_EXC_NONE));
        chk("part_watch", 64'(rsp.exc), 64'(AEC_EXC_WATCH));
        go(row(AEC_OP_FLUSH, 64'h8000_0000_0000, 8'h00, 3'h7, AEC_EXC_NONE));
        chk("sync_coh", {rsp.exc, rsp.mmu_lookup}, 64'h0);
        acc(1'b1, AEC_CFG_OFF, 64'h6);
        go(row(AEC_OP_FLUSH, 64'h0, 8'h00, 3'h7, AEC_EXC_NONE));
        chk("sync_mmu", rsp.mmu_lookup, 64'h1);
        go(rows[12]);
        chk("blk_strict", 64'(rsp.exc), 64'(AEC_EXC_NONE));
        $display("table test done");
        acc(1'b0, AEC_STAT_OFF, 64'h0);
        chk("status", rdv, 64'h1F);
        acc(1'b1, AEC_CLR_OFF, 64'h1F);
        acc(1'b1, AEC_EN_OFF, 64'h1);
        chk("irq_clear", irq_o, 64'h0);
        go(rows[0]);
        chk("irq_set", irq_o, 64'h1);
        acc(1'b1, AEC_EN_OFF, 64'h2);
        chk("irq_mask", irq_o, 64'h0);
        $display("interrupt test done");
        chk("max_gl", AEC_MAX_GL inside {[4'h2:4'hF]}, 64'h1);
        acc(1'b1, AEC_GL_OFF, 64'hF);
        acc(1'b0, AEC_GL_OFF, 64'h0);
        chk("level_sat", rdv, {60'h0, AEC_MAX_GL});
        acc(1'b1, AEC_GL_OFF, 64'hFFFF_FFFF_FFFF_FFF2);
        acc(1'b0, AEC_GL_OFF, 64'h0);
        chk("level_hi", rdv, 64'h2);
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, 8'(i), 64'hA5A5_0000_0000_0000 | 64'(i));
            chk("busy", reg_busy_o, i >= 6);
        end
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, 8'(i), 64'h0);
            chk("scratch", rdv, i < 7 ? 64'hA5A5 << 48 | i : 0);
            chk("scr_fault", flt, i == 7);
        end
        @(posedge clk_i);
        reg_priv_i <= 1'b0;
        acc(1'b0, 8'h00, 64'h0);
        chk("scr_unpriv", flt, 64'h1);
        chk("scr_unpriv_rd", rdv, 64'h0);
        @(posedge clk_i);
        reg_priv_i <= 1'b1;
        acc(1'b0, 8'h20, 64'h0);
        chk("unmapped", rdv, 64'h0);
        $display("register test done");
        for (int i = 0; i < 2; i++)
        begin
            acc(1'b1, AEC_FPRS_OFF, 64'h0);
            @(posedge clk_i);
            fp_wr_i <= 1'b1;
            fp_wr_reg_i <= i ? 6'h28 : 6'h03;
            @(posedge clk_i);
            fp_wr_i <= 1'b0;
            acc(1'b0, AEC_FPRS_OFF, 64'h0);
            chk("dirty", rdv, i ? 64'h2 : 64'h1);
        end
        trap(1'b1);
        chk("am_set", address_mask_bit_o, 64'h1);
        chk("pc_full", pc_o, ret_pc_i);
        acc(1'b1, AEC_CFG_OFF, 64'h8);
        trap(1'b1);
        chk("pc_low", pc_o, {32'h0, ret_pc_i[31:0]});
        chk("npc_low", npc_o, {32'h0, ret_npc_i[31:0]});
        trap(1'b0);
        chk("am_clr", address_mask_bit_o, 64'h0);
        chk("pc_unmasked", pc_o, ret_pc_i);
        $display("trap return test done");
        end_of_test();
    end
endmodule // aec_core_tb_top
